//--- hdl/target_port_pkg.sv
// Shared constants and types of the two-wire target port
package target_port_pkg;
    // Core clock rate and glitch filter sizing
    localparam int CORE_CLK_MHZ = 125;
    localparam int SPIKE_NS = 50;
    localparam int FILTER_CYCLES = (SPIKE_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam logic [2:0] FILTER_MAX = 3'(FILTER_CYCLES);
    // Target address and framing
    localparam logic [6:0] TARGET_ADDR = 7'h28;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;
    // Transfer phases of the target
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } phase_t;
endpackage

//--- hdl/byte_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    // Full and empty from pointer compare
    assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk) begin
        if (!rstn || flush) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // byte_fifo

//--- hdl/smbus_i2c_target_port.sv
// Two-wire target port: bus decoding, register pointer and write stream
`timescale 1ns/1ps
module smbus_i2c_target_port
    import target_port_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe_n,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_req,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic busy
);
    import target_port_pkg::*;

    // ------------------------------------------------------------
    // Line conditioning
    // ------------------------------------------------------------
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_q;
    logic sda_q;
    logic [2:0] scl_cnt_q;
    logic [2:0] sda_cnt_q;

    // Filter step: follow input only after it holds steady
    function automatic logic [2:0] filt_cnt(input logic raw, input logic cur,
                                            input logic [2:0] cnt);
        filt_cnt = (raw == cur) ? 3'h0 : cnt + 3'h1;
    endfunction

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
        end else begin
            scl_sync_q <= {scl_sync_q[0], serial_clock_pin_i};
            sda_sync_q <= {sda_sync_q[0], serial_data_pin_i};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_cnt_q <= 3'h0;
            sda_cnt_q <= 3'h0;
        end else begin
            scl_cnt_q <= filt_cnt(scl_sync_q[1], scl_q, scl_cnt_q);
            sda_cnt_q <= filt_cnt(sda_sync_q[1], sda_q, sda_cnt_q);
            if (scl_sync_q[1] != scl_q && scl_cnt_q >= FILTER_MAX) begin
                scl_q <= scl_sync_q[1];
                scl_cnt_q <= 3'h0;
            end
            if (sda_sync_q[1] != sda_q && sda_cnt_q >= FILTER_MAX) begin
                sda_q <= sda_sync_q[1];
                sda_cnt_q <= 3'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    // edges only; a held-low clock simply stalls
    assign scl_rise = scl_q && !scl_prev_q;
    assign scl_fall = !scl_q && scl_prev_q;
    assign start_ev = scl_q && scl_prev_q && sda_prev_q && !sda_q;
    assign stop_ev = scl_q && scl_prev_q && !sda_prev_q && sda_q;

    // ------------------------------------------------------------
    // Write stream buffer
    // ------------------------------------------------------------
    logic fifo_in_valid_q;
    logic fifo_in_ready;
    logic [15:0] fifo_in_data_q;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic fifo_pop;

    byte_fifo #(
        .WIDTH(2 * BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(core_clk),
        .rstn(rstn),
        .flush(1'b0),
        .in_valid(fifo_in_valid_q),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    phase_t phase_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic [7:0] tx_q;
    logic ack_drive_q;
    logic tx_drive_q;
    logic host_ack_q;
    logic byte_done;
    logic [7:0] rx_byte;
    logic addr_hit_q;

    assign byte_done = scl_rise && (bit_q == BIT_LAST);
    assign rx_byte = {shift_q[6:0], sda_q};

    // Bit counter and receive shifter, sampling on clock rise
    always_ff @(posedge core_clk) begin
        if (!rstn || start_ev) begin
            bit_q <= '1; // Clock fall closing the start lands on bit 0
            shift_q <= 8'h00;
            addr_hit_q <= 1'b0;
        end else if (scl_rise) begin
            shift_q <= rx_byte;
            if (bit_q == BIT_LAST) begin
                addr_hit_q <= (phase_q == ST_ADDR) && (rx_byte[7:1] == TARGET_ADDR);
            end
            if (bit_q == BIT_ACK) begin
                host_ack_q <= !sda_q;
            end
        end else if (scl_fall) begin
            bit_q <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            phase_q <= ST_IDLE;
        end else if (start_ev) begin
            phase_q <= ST_ADDR;
        end else if (stop_ev) begin
            phase_q <= ST_IDLE;
        end else if (byte_done) begin
            case (phase_q)
                ST_ADDR: begin
                    if (rx_byte[7:1] != TARGET_ADDR) begin
                        phase_q <= ST_IGNORE;
                    end else if (rx_byte[0]) begin
                        phase_q <= ST_RDATA;
                    end else begin
                        phase_q <= ST_PTR;
                    end
                end
                ST_PTR: phase_q <= ST_WDATA;
                ST_WDATA: phase_q <= ST_WDATA;
                ST_RDATA: phase_q <= ST_RDATA;
                ST_IGNORE: phase_q <= ST_IGNORE;
                default: phase_q <= ST_IDLE;
            endcase
        end else if (phase_q == ST_RDATA && scl_rise && bit_q == BIT_ACK && sda_q) begin
            // Host NACK ends the read stream
            phase_q <= ST_IGNORE;
        end
    end

    // pointer load and auto-increment with wrap
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ptr_q <= PTR_RESET;
        end else if (byte_done && phase_q == ST_PTR) begin
            ptr_q <= rx_byte;
        end else if (byte_done && phase_q == ST_WDATA) begin
            ptr_q <= ptr_q + PTR_STEP;
        end else if (phase_q == ST_RDATA && scl_rise && bit_q == BIT_LAST) begin
            ptr_q <= ptr_q + PTR_STEP;
        end
    end

    // Write stream entry: pointer with data
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fifo_in_valid_q <= 1'b0;
            fifo_in_data_q <= 16'h0000;
        end else begin
            fifo_in_valid_q <= byte_done && phase_q == ST_WDATA && fifo_in_ready;
            fifo_in_data_q <= {ptr_q, rx_byte};
        end
    end

    // Read request: fetch byte at pointer when a read byte begins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rd_req <= 1'b0;
            rd_addr <= PTR_RESET;
            tx_q <= 8'h00;
        end else begin
            rd_req <= scl_fall && phase_q == ST_RDATA && bit_q == BIT_ACK;
            rd_addr <= ptr_q;
            if (rd_req) begin
                tx_q <= rd_data;
            end else if (scl_fall && phase_q == ST_RDATA && bit_q < BIT_LAST) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // acknowledge drive; data out during read bits
    always_ff @(posedge core_clk) begin
        if (!rstn || start_ev || stop_ev) begin
            ack_drive_q <= 1'b0;
            tx_drive_q <= 1'b0;
        end else if (scl_fall) begin
            ack_drive_q <= (bit_q == BIT_LAST) && (phase_q == ST_PTR || phase_q == ST_WDATA
                || addr_hit_q);
            tx_drive_q <= (phase_q == ST_RDATA) && (bit_q != BIT_LAST) && !host_ack_q_n();
        end
    end

    // Host acknowledge state after each read byte
    function automatic logic host_ack_q_n();
        host_ack_q_n = (bit_q == BIT_ACK) && !host_ack_q;
    endfunction

    // Pin drivers: open drain, enable low while driving
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            serial_data_pin_o <= 1'b0;
            serial_data_pin_oe_n <= 1'b1;
            serial_clock_pin_o <= 1'b0;
            serial_clock_pin_oe_n <= 1'b1;
        end else begin
            serial_data_pin_o <= 1'b0;
            serial_data_pin_oe_n <= !(ack_drive_q || (tx_drive_q && !rd_req && !tx_q[7]));
            // clock line is only ever released
            serial_clock_pin_o <= 1'b0;
            serial_clock_pin_oe_n <= 1'b1;
        end
    end

    // User-side write stream and status
    assign fifo_pop = wr_ready || !wr_valid;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_valid <= 1'b0;
            wr_addr <= PTR_RESET;
            wr_data <= 8'h00;
            busy <= 1'b0;
        end else begin
            if (fifo_pop) begin
                wr_valid <= fifo_out_valid;
                wr_addr <= fifo_out_data[15:8];
                wr_data <= fifo_out_data[7:0];
            end
            busy <= (phase_q inside {ST_PTR, ST_WDATA, ST_RDATA}) || (phase_q == ST_ADDR && busy);
        end
    end
endmodule // smbus_i2c_target_port

//--- test/port_checker.sv
// Concurrent checks on the pins and streams of the two-wire target port
`timescale 1ns/1ps
module port_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic serial_clock_pin_i,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe_n,
    input wire logic serial_data_pin_i,
    input wire logic serial_data_pin_o,
    input wire logic serial_data_pin_oe_n,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_req,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    scl_release_a: assert property (serial_clock_pin_oe_n)
        else $error("clock line pulled low");
    reset_idle_a: assert property (@(posedge core_clk) disable iff (1'b0)
        !rstn |=> serial_data_pin_oe_n && !wr_valid && !rd_req && !busy)
        else $error("outputs not idle after reset");
    sda_change_low_a: assert property ($changed(serial_data_pin_oe_n)
        |-> !serial_clock_pin_i && !$past(serial_clock_pin_i)) else $error("data moved in high clock");
    filter_delay_a: assert property ($fell(serial_data_pin_oe_n)
        |-> $past(serial_clock_pin_i, 5) == 1'b0) else $error("drive too soon after clock fall");
    ack_hold_a: assert property ($fell(serial_data_pin_oe_n)
        |-> !serial_data_pin_oe_n [*8]) else $error("data low pulse too short");
    rd_pulse_a: assert property (rd_req |=> !rd_req)
        else $error("read request longer than one cycle");
    rd_busy_a: assert property (rd_req |-> busy)
        else $error("read request while not addressed");
    wr_hold_a: assert property (wr_valid && !wr_ready
        |=> wr_valid && $stable({wr_addr, wr_data})) else $error("write entry changed while stalled");
    busy_end_a: assert property ($fell(busy)
        |-> serial_clock_pin_i && serial_data_pin_i) else $error("busy ended without stop");
    cover property (wr_valid && wr_ready);
    cover property (rd_req);
    cover property ($fell(busy));
endmodule // port_checker

bind smbus_i2c_target_port port_checker u_port_checker (
    .core_clk(core_clk), .rstn(rstn), .serial_clock_pin_i(serial_clock_pin_i),
    .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
    .serial_data_pin_i(serial_data_pin_i), .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe_n(serial_data_pin_oe_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .busy(busy)
);

//--- test/host_model.sv
// Behavioural bus host that drives clock and data as open-drain lines
`timescale 1ns/1ps
module host_model (
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    int half_ns = 320;
    int stretch_ns = 0;
    // Both lines released at start
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic start();
        sda_o = 1'b1;
        #(half_ns / 2);
        scl_o = 1'b1;
        #(half_ns);
        sda_o = 1'b0;
        #(half_ns);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        #(half_ns / 2);
        sda_o = 1'b0;
        #(half_ns / 2);
        scl_o = 1'b1;
        #(half_ns);
        sda_o = 1'b1;
        #(half_ns);
    endtask
    task automatic pulse(input logic b, output logic s);
        #(half_ns / 2);
        sda_o = b;
        #(half_ns / 2 + stretch_ns);
        scl_o = 1'b1;
        #(half_ns / 2);
        s = sda_i;
        #(half_ns / 2);
        scl_o = 1'b0;
    endtask
    // Short clock noise in low phase
    task automatic spike();
        #(half_ns / 2);
        scl_o = 1'b1;
        #16;
        scl_o = 1'b0;
    endtask
    // Byte out, most significant first, then ack slot
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) pulse(b[i], s);
        pulse(1'b1, ack);
    endtask
    // Byte in, then ack or nack
    task automatic recv(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b1, s);
            b[i] = s;
        end
        pulse(last, s);
    endtask
endmodule // host_model

//--- test/test_smbus_i2c_target_port.sv
// Self-checking bench of the two-wire target port
`timescale 1ns/1ps
module test_smbus_i2c_target_port;
    import target_port_pkg::*;
    typedef struct packed {logic [7:0] ptr; logic [7:0] val;} row_t;
    row_t rows [4] = '{'{8'h00, 8'hA5}, '{8'h7F, 8'h3C}, '{8'hFF, 8'h01}, '{8'h28, 8'hC3}};
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic wr_ready = 1'b0;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, host_scl, host_sda, wr_valid, rd_req, busy;
    logic [7:0] wr_addr, wr_data, rd_addr;
    logic [7:0] mem [256];
    logic [7:0] model [256];
    logic [15:0] taken [$];
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    wire scl = host_scl & (scl_oe_n | scl_o);
    wire sda = host_sda & (sda_oe_n | sda_o);
    wire [7:0] rd_data = mem[rd_addr];

    always #4 core_clk = ~core_clk;
    smbus_i2c_target_port dut (.core_clk(core_clk), .rstn(rstn), .serial_clock_pin_i(scl),
        .serial_clock_pin_o(scl_o), .serial_clock_pin_oe_n(scl_oe_n), .serial_data_pin_i(sda),
        .serial_data_pin_o(sda_o), .serial_data_pin_oe_n(sda_oe_n), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
    host_model host (.scl_o(host_scl), .sda_o(host_sda), .sda_i(sda));

    // Register sink, entry log and run limit
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (wr_valid && wr_ready) begin
            taken.push_back({wr_addr, wr_data});
            mem[wr_addr] <= wr_data;
        end
        if (cycles == 90000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: bit %b want %b", $time, got, exp);
        end
    endtask
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: value %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        for (int t = 0; t < 400 && (wr_valid !== 1'b0 || busy !== 1'b0); t++) @(negedge core_clk);
    endtask
    // write address, pointer and n data bytes, no stop
    task automatic write_seq(input logic [7:0] ptr, input int n, input logic [7:0] first);
        logic a;
        host.start();
        host.spike();
        host.send({TARGET_ADDR, 1'b0}, a);
        check_bit(a, 1'b0);
        host.send(ptr, a);
        check_bit(a, 1'b0);
        for (int i = 0; i < n; i++) begin
            host.send(first + 8'(i), a);
            check_bit(a, 1'b0);
            if (i <= FIFO_DEPTH) model[ptr + 8'(i)] = first + 8'(i); // Queue plus output stage
        end
    endtask
    // read n bytes, nack the last, then stop
    task automatic read_seq(input logic [7:0] ptr, input int n);
        logic a;
        logic [7:0] b;
        host.start();
        host.send({TARGET_ADDR, 1'b1}, a);
        check_bit(a, 1'b0);
        check_bit(busy, 1'b1);
        for (int i = 0; i < n; i++) begin
            host.recv(i == n - 1, b);
            check_val({8'h00, b}, {8'h00, model[ptr + 8'(i)]});
        end
        host.stop();
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Main sequence
    initial begin
        logic a;
        foreach (mem[i]) begin
            mem[i] = 8'h00;
            model[i] = 8'h00;
        end
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check_bit(sda_oe_n, 1'b1);
        check_bit(busy, 1'b0);
        rstn = 1'b1;
        wr_ready = 1'b1;
        foreach (rows[k]) begin
            write_seq(rows[k].ptr, 1, rows[k].val);
            host.stop();
            wait_idle();
            check_val(16'(taken.size()), 16'h0001);
            check_val(taken.pop_front(), {rows[k].ptr, rows[k].val});
            write_seq(rows[k].ptr, 0, 8'h00);
            read_seq(rows[k].ptr, 1);
            write_seq(rows[k].ptr, 0, 8'h00);
            host.stop();
            read_seq(rows[k].ptr, 1);
        end
        host.start();
        host.send({TARGET_ADDR ^ 7'h01, 1'b0}, a);
        check_bit(a, 1'b1);
        host.send(8'h55, a);
        check_bit(a, 1'b1);
        host.stop();
        check_bit(busy, 1'b0);
        check_val(16'(taken.size()), 16'h0000);
        wr_ready = 1'b0;
        host.stretch_ns = 400;
        write_seq(8'hF8, 18, 8'h40);
        host.stop();
        host.stretch_ns = 0;
        check_bit(wr_valid, 1'b1);
        wr_ready = 1'b1;
        wait_idle();
        check_val(16'(taken.size()), 16'(FIFO_DEPTH + 1));
        foreach (taken[i]) check_val(taken[i], {8'hF8 + 8'(i), 8'h40 + 8'(i)});
        write_seq(8'hFE, 0, 8'h00);
        read_seq(8'hFE, 4);
        tally_and_finish();
    end
endmodule // test_smbus_i2c_target_port
